//--- verilog/page_mapping_regs.sv
`default_nettype none
module page_mapping_regs (
  input wire logic clk,
  input wire logic rst,
  // Coprocessor move port
  input wire logic cop_wr,
  input wire logic cop_rd,
  input wire logic cop_high,
  input wire logic [4:0] cop_index,
  input wire logic [31:0] cop_wdata,
  output logic [31:0] cop_rdata,
  output logic cop_rvalid,
  // Layout controls
  input wire logic small_page_enable,
  input wire logic large_addr_enable,
  output logic small_page_capability,
  output logic large_addr_capability,
  // Translation array side
  input wire logic write_translation,
  input wire logic read_translation,
  input wire page_mapping_pkg::entry_type tlb_rd_entry,
  output page_mapping_pkg::entry_type tlb_wr_entry,
  output logic tlb_wr_valid,
  // Matching of a stored entry
  input wire logic probe_vpn_hit,
  input wire logic probe_global,
  input wire logic [page_mapping_pkg::TAG_WIDTH-1:0] probe_tag,
  input wire logic [page_mapping_pkg::TAG_WIDTH-1:0] address_space_tag,
  output logic tag_hit,
  // Access permission check of a matched page
  input wire logic access_req,
  input wire logic access_store,
  input wire logic access_dirty,
  input wire logic access_valid,
  output logic modified_exc,
  output logic invalid_exc,
  // Exception side effects
  input wire logic address_error,
  input wire logic virtual_side_write,
  input wire logic fault_capture,
  output logic fault_addr_update
);
  import page_mapping_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  // All registered state of the block
  typedef struct packed {
    map_type [1:0] maps;  // Even at 0, odd at 1
    logic [31:0] rdata;  // Read data of the last move
    logic rvalid;  // Read data strobe
    entry_type entry;  // Entry presented to the array
    logic entry_wr;  // Entry write strobe
    logic fault_update;  // Fault register update strobe
  } state_type;

  state_type st;  // Current state
  state_type next_st;  // Next state

  logic small_mode;  // Small-page layout active
  logic large_mode;  // Extended layout active
  logic [FRAME_BITS-1:0] mask;  // Implemented frame bits
  logic [1:0] wr_slot;  // Write target decode
  logic [1:0] rd_slot;  // Read target decode

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Hit flag in bit 1, odd select in bit 0
  function automatic logic [1:0] decode_slot(input logic [4:0] idx);
    logic [1:0] res;
    res = 2'b00;
    if (idx == EVEN_INDEX) begin
      res = 2'b10;
    end else if (idx == ODD_INDEX) begin
      res = 2'b11;
    end
    return res;
  endfunction : decode_slot

  // Masked frame of one register
  function automatic logic [FRAME_BITS-1:0] frame_of(input map_type m, input logic [FRAME_BITS-1:0] msk);
    return {m.high, m.low[FRAME_MSB:FRAME_LSB]} & msk;
  endfunction : frame_of

  // Capability flags are fixed; the first release never offers small pages
  assign small_page_capability = SMALL_PAGE_SUPPORT & ~FIRST_RELEASE;
  assign large_addr_capability = LARGE_ADDR_SUPPORT;

  // Layout selection from capability and enable
  assign small_mode = small_page_capability & small_page_enable;
  assign large_mode = large_addr_capability & large_addr_enable;

  // Width-dependent boundary between frame and pad
  assign mask = frame_mask(small_mode, large_mode);

  assign wr_slot = decode_slot(cop_index);
  assign rd_slot = decode_slot(cop_index);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Register updates, entry transfer and read data
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.entry_wr = 1'b0;
    // Only an exception captures the fault address, never a virtual write
    next_st.fault_update = fault_capture;

    // Address error leaves the registers as they are; that is a legal choice
    if (address_error) begin
      next_st.maps = st.maps;
    end

    // Entry write: export both pages and the combined global flag
    if (write_translation) begin
      for (int i = 0; i < 2; i++) begin
        next_st.entry.pages[i].frame = frame_of(st.maps[i], mask);
        next_st.entry.pages[i].attr = st.maps[i].low[ATTR_MSB:ATTR_LSB];
        next_st.entry.pages[i].dirty = st.maps[i].low[DIRTY_BIT];
        next_st.entry.pages[i].valid = st.maps[i].low[VALID_BIT];
        next_st.entry.pages[i].base = page_base(frame_of(st.maps[i], mask), small_mode);
      end
      next_st.entry.space_ignore = st.maps[0].low[GLOBAL_BIT] & st.maps[1].low[GLOBAL_BIT];
      next_st.entry_wr = 1'b1;
    end

    // Entry read: load both registers, global copied into each
    if (read_translation) begin
      for (int i = 0; i < 2; i++) begin
        next_st.maps[i].low[FRAME_MSB:FRAME_LSB] = tlb_rd_entry.pages[i].frame[23:0] & mask[23:0];
        next_st.maps[i].high = tlb_rd_entry.pages[i].frame[46:24] & mask[46:24];
        next_st.maps[i].low[ATTR_MSB:ATTR_LSB] = tlb_rd_entry.pages[i].attr;
        next_st.maps[i].low[DIRTY_BIT] = tlb_rd_entry.pages[i].dirty;
        next_st.maps[i].low[VALID_BIT] = tlb_rd_entry.pages[i].valid;
        next_st.maps[i].low[GLOBAL_BIT] = tlb_rd_entry.space_ignore;
      end
    end

    // Software write; it follows the array load so the later move wins
    if (cop_wr && wr_slot[1]) begin
      if (cop_high) begin
        // Upper half exists only while the extended layout is on
        if (large_mode) begin
          next_st.maps[wr_slot[0]].high = cop_wdata[22:0] & mask[46:24];
        end
      end else begin
        // Pad bits 31..30 fall outside the stored bits 29..0 and are never stored
        next_st.maps[wr_slot[0]].low[FRAME_MSB:FRAME_LSB] = cop_wdata[FRAME_MSB:FRAME_LSB] & mask[23:0];
        next_st.maps[wr_slot[0]].low[5:0] = cop_wdata[5:0];
      end
    end

    // Software read; unmapped numbers answer zero
    if (cop_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 32'h00000000;
      if (rd_slot[1]) begin
        if (cop_high) begin
          if (large_mode) begin
            next_st.rdata = {9'h000, st.maps[rd_slot[0]].high & mask[46:24]};
          end
        end else begin
          // Only implemented frame bits come back as ones
          next_st.rdata = {2'b00, st.maps[rd_slot[0]].low[FRAME_MSB:FRAME_LSB] & mask[23:0],
                           st.maps[rd_slot[0]].low[5:0]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Single state register; contents of the mapping are cleared at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        st.maps[i].low <= LOW_RESET;
        st.maps[i].high <= HIGH_RESET;
      end
      st.rdata <= 32'h00000000;
      st.rvalid <= 1'b0;
      st.entry <= '0;
      st.entry_wr <= 1'b0;
      st.fault_update <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cop_rdata = st.rdata;
  assign cop_rvalid = st.rvalid;
  assign tlb_wr_entry = st.entry;
  assign tlb_wr_valid = st.entry_wr;
  assign fault_addr_update = st.fault_update;

  // Global entries match any address space
  assign tag_hit = probe_vpn_hit & (probe_global | (probe_tag == address_space_tag));

  // Invalid takes precedence; a store to a clean page is trapped
  assign invalid_exc = access_req & ~access_valid;
  assign modified_exc = access_req & access_valid & access_store & ~access_dirty;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_fill_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (cop_rd && !cop_high && decode_slot(cop_index) == 2'b10) |=> (cop_rvalid && cop_rdata[31:30] == 2'b00))
    else $error("pad bits read nonzero");

  a_all_ones_probe: assert property (@(posedge clk) disable iff (rst)
    (cop_wr && !cop_high && cop_index == EVEN_INDEX && cop_wdata == 32'hffffffff && !read_translation
     ##1 (cop_rd && !cop_high && cop_index == EVEN_INDEX && !cop_wr && !read_translation && $stable(mask)))
    |=> (cop_rdata[29:6] == mask[23:0]))
    else $error("all ones write does not read back frame mask");

  a_global_and: assert property (@(posedge clk) disable iff (rst)
    write_translation |=> (tlb_wr_valid && tlb_wr_entry.space_ignore == ($past(st.maps[0].low[0])
                                                                          & $past(st.maps[1].low[0]))))
    else $error("entry global is not the AND of both registers");

  a_global_copy: assert property (@(posedge clk) disable iff (rst)
    (read_translation && !cop_wr) |=> (st.maps[0].low[0] == $past(tlb_rd_entry.space_ignore)
                                       && st.maps[1].low[0] == $past(tlb_rd_entry.space_ignore)))
    else $error("entry global not copied into both registers");

  a_global_skip: assert property (@(posedge clk) disable iff (rst)
    (probe_vpn_hit && probe_global) |-> tag_hit)
    else $error("global entry failed to match");

  a_store_denied: assert property (@(posedge clk) disable iff (rst)
    (access_req && access_valid && access_store && !access_dirty) |-> (modified_exc && !invalid_exc))
    else $error("store to clean page not trapped");

  a_invalid_access: assert property (@(posedge clk) disable iff (rst)
    (access_req && !access_valid) |-> (invalid_exc && !modified_exc))
    else $error("access to invalid page not trapped");

  a_large_base: assert property (@(posedge clk) disable iff (rst)
    (write_translation && !small_mode) |=> (tlb_wr_entry.pages[0].base[35:12] == tlb_wr_entry.pages[0].frame[23:0]
                                           && tlb_wr_entry.pages[0].base[11:0] == 12'h000))
    else $error("large page base misaligned");

  a_small_base: assert property (@(posedge clk) disable iff (rst)
    (write_translation && small_mode) |=> (tlb_wr_entry.pages[1].base[33:10] == tlb_wr_entry.pages[1].frame[23:0]))
    else $error("small page base misaligned");

  a_high_hidden: assert property (@(posedge clk) disable iff (rst)
    (cop_rd && cop_high && !large_mode) |=> (cop_rdata == 32'h00000000))
    else $error("upper half visible without extended layout");

  a_fault_only_exc: assert property (@(posedge clk) disable iff (rst)
    (virtual_side_write && !fault_capture) |=> !fault_addr_update)
    else $error("virtual write updated fault registers");

  // Strobes, pads, loads, exports, matching and permissions; each consequent checks what this block drives
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
    cop_rd |=> cop_rvalid)
    else $error("read strobe not answered");

  a_rvalid_idle: assert property (@(posedge clk) disable iff (rst)
    !cop_rd |=> !cop_rvalid)
    else $error("read answer without a read");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    (cop_rd && cop_index != EVEN_INDEX && cop_index != ODD_INDEX) |=> (cop_rdata == 32'h00000000))
    else $error("unmapped register read nonzero");

  a_low_pad_zero: assert property (@(posedge clk) disable iff (rst)
    (cop_rd && !cop_high) |=> (cop_rdata[31:30] == 2'b00))
    else $error("low word pad read nonzero");

  a_high_pad_zero: assert property (@(posedge clk) disable iff (rst)
    (cop_rd && cop_high) |=> (cop_rdata[31:23] == 9'h000))
    else $error("upper half pad read nonzero");

  a_read_frame: assert property (@(posedge clk) disable iff (rst)
    (read_translation && !cop_wr) |=> (st.maps[0].low[FRAME_MSB:FRAME_LSB]
                                       == ($past(tlb_rd_entry.pages[0].frame[23:0]) & $past(mask[23:0]))))
    else $error("entry read frame not loaded");

  a_error_keeps: assert property (@(posedge clk) disable iff (rst)
    (address_error && !cop_wr && !read_translation) |=> (st.maps == $past(st.maps)))
    else $error("address error changed the registers");

  a_strobe_idle: assert property (@(posedge clk) disable iff (rst)
    !write_translation |=> !tlb_wr_valid)
    else $error("entry strobe without a write");

  a_even_attr: assert property (@(posedge clk) disable iff (rst)
    write_translation |=> (tlb_wr_entry.pages[0].attr == $past(st.maps[0].low[ATTR_MSB:ATTR_LSB])))
    else $error("even attribute not exported");

  a_odd_attr: assert property (@(posedge clk) disable iff (rst)
    write_translation |=> (tlb_wr_entry.pages[1].attr == $past(st.maps[1].low[ATTR_MSB:ATTR_LSB])))
    else $error("odd attribute not exported");

  a_even_flags: assert property (@(posedge clk) disable iff (rst)
    write_translation |=> (tlb_wr_entry.pages[0].dirty == $past(st.maps[0].low[DIRTY_BIT])
                           && tlb_wr_entry.pages[0].valid == $past(st.maps[0].low[VALID_BIT])))
    else $error("even permission flags not exported");

  a_odd_flags: assert property (@(posedge clk) disable iff (rst)
    write_translation |=> (tlb_wr_entry.pages[1].dirty == $past(st.maps[1].low[DIRTY_BIT])
                           && tlb_wr_entry.pages[1].valid == $past(st.maps[1].low[VALID_BIT])))
    else $error("odd permission flags not exported");

  a_tag_compare: assert property (@(posedge clk) disable iff (rst)
    (probe_vpn_hit && !probe_global) |-> (tag_hit == (probe_tag == address_space_tag)))
    else $error("private entry tag compare wrong");

  a_miss_no_hit: assert property (@(posedge clk) disable iff (rst)
    !probe_vpn_hit |-> !tag_hit)
    else $error("hit without a page match");

  a_store_allowed: assert property (@(posedge clk) disable iff (rst)
    (access_req && access_valid && access_dirty) |-> (!modified_exc && !invalid_exc))
    else $error("access to writable page trapped");

  a_fault_follows: assert property (@(posedge clk) disable iff (rst)
    fault_capture |=> fault_addr_update)
    else $error("exception did not capture fault address");

endmodule : page_mapping_regs
`default_nettype wire

//--- verilog/page_mapping_pkg.sv
`default_nettype none
package page_mapping_pkg;

  // Coprocessor register numbers of the two mapping registers
  localparam logic [4:0] EVEN_INDEX = 5'h02;
  localparam logic [4:0] ODD_INDEX = 5'h03;

  // Field positions inside the low word
  localparam int FRAME_MSB = 29;
  localparam int FRAME_LSB = 6;
  localparam int ATTR_MSB = 5;
  localparam int ATTR_LSB = 3;
  localparam int DIRTY_BIT = 2;
  localparam int VALID_BIT = 1;
  localparam int GLOBAL_BIT = 0;

  // Frame bits held in the low word and in the upper half
  localparam int FRAME_LOW_BITS = 24;
  localparam int FRAME_HIGH_BITS = 23;
  localparam int FRAME_BITS = 47;

  // Implemented physical address width, extended range (40..59)
  localparam int PHYS_ADDR_WIDTH = 40;
  localparam int BASE_BITS = 59;

  // Page offset widths of large and small pages
  localparam int LARGE_PAGE_SHIFT = 12;
  localparam int SMALL_PAGE_SHIFT = 10;

  // Address space tag width
  localparam int TAG_WIDTH = 8;

  // Implementation options
  localparam logic FIRST_RELEASE = 1'b0;
  localparam logic SMALL_PAGE_SUPPORT = 1'b1;
  localparam logic LARGE_ADDR_SUPPORT = 1'b1;

  // Reset values of the storage
  localparam logic [29:0] LOW_RESET = 30'h00000000;
  localparam logic [22:0] HIGH_RESET = 23'h000000;

  // One mapping register: low word bits 29..0 and upper half bits 22..0
  typedef struct packed {
    logic [22:0] high;
    logic [29:0] low;
  } map_type;

  // One page of a translation entry, frame aligned to register bit 6
  typedef struct packed {
    logic [FRAME_BITS-1:0] frame;
    logic [2:0] attr;
    logic dirty;
    logic valid;
    logic [BASE_BITS-1:0] base;
  } page_type;

  // Whole translation entry as exchanged with the array
  typedef struct packed {
    page_type [1:0] pages;
    logic space_ignore;  // Entry matches every address space tag
  } entry_type;

  // Mask of implemented frame bits for the active layout
  function automatic logic [FRAME_BITS-1:0] frame_mask(input logic small_mode, input logic large_mode);
    int n;
    n = small_mode ? PHYS_ADDR_WIDTH - SMALL_PAGE_SHIFT : PHYS_ADDR_WIDTH - LARGE_PAGE_SHIFT;
    if (!large_mode && n > FRAME_LOW_BITS) begin
      n = FRAME_LOW_BITS;
    end
    return ~({FRAME_BITS{1'b1}} << n);
  endfunction : frame_mask

  // Physical base address of a page from its frame
  function automatic logic [BASE_BITS-1:0] page_base(input logic [FRAME_BITS-1:0] frame, input logic small_mode);
    logic [BASE_BITS-1:0] wide;
    wide = {12'h000, frame};
    return small_mode ? (wide << SMALL_PAGE_SHIFT) : (wide << LARGE_PAGE_SHIFT);
  endfunction : page_base

endpackage : page_mapping_pkg
`default_nettype wire

//--- test/tlb_array_model.sv
`default_nettype none
module tlb_array_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic read_translation,
  input wire logic tlb_wr_valid,
  input wire page_mapping_pkg::entry_type tlb_wr_entry,
  output page_mapping_pkg::entry_type tlb_rd_entry
);
  timeunit 1ns;
  timeprecision 1ps;
  import page_mapping_pkg::*;

  entry_type stored; // Single entry of the array

  ////////////////////////////////////////////////////////////////////////////////
  // Capture what the block writes, global already folded to one bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stored <= '0;
    end else if (tlb_wr_valid) begin
      stored <= tlb_wr_entry;
    end
  end

  // Inverted junk outside a read, so a stray sample never looks right
  assign tlb_rd_entry = read_translation ? stored : ~stored;
endmodule : tlb_array_model
`default_nettype wire

//--- test/tlb_entry_low_regs_bench.sv
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tlb_entry_low_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import page_mapping_pkg::*;

  logic clk = 0, rst = 1, cop_wr = 0, cop_rd = 0, cop_high = 0; // Clock, reset, move strobes
  logic [4:0] cop_index = '0; // Register number
  logic [31:0] cop_wdata = '0, cop_rdata, ev, od; // Move data and random words
  logic cop_rvalid, small_page_capability, large_addr_capability, tlb_wr_valid, tag_hit;
  logic small_page_enable = 0, large_addr_enable = 0, write_translation = 0, read_translation = 0;
  logic probe_vpn_hit = 0, probe_global = 0, access_req = 0, access_store = 0;
  logic access_dirty = 0, access_valid = 0, address_error = 0, virtual_side_write = 0, fault_capture = 0;
  logic modified_exc, invalid_exc, fault_addr_update, fc, sp, g; // Outputs and saved stimulus
  logic [TAG_WIDTH-1:0] probe_tag = '0, address_space_tag = '0; // Address space tags
  entry_type tlb_rd_entry, tlb_wr_entry; // Entries to and from the array
  int error_cnt = 0, n_tests = 0; // Mismatch and comparison counts

  ////////////////////////////////////////////////////////////////////////////////
  // Block and its array partner
  page_mapping_regs dut (.clk, .rst, .cop_wr, .cop_rd, .cop_high, .cop_index, .cop_wdata, .cop_rdata,
    .cop_rvalid, .small_page_enable, .large_addr_enable, .small_page_capability, .large_addr_capability,
    .write_translation, .read_translation, .tlb_rd_entry, .tlb_wr_entry, .tlb_wr_valid, .probe_vpn_hit,
    .probe_global, .probe_tag, .address_space_tag, .tag_hit, .access_req, .access_store, .access_dirty,
    .access_valid, .modified_exc, .invalid_exc, .address_error, .virtual_side_write, .fault_capture,
    .fault_addr_update);
  tlb_array_model array (.clk, .rst, .read_translation, .tlb_wr_valid, .tlb_wr_entry, .tlb_rd_entry);

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Upper half expected after an all-ones write: frame bits above the low word
  function automatic logic [31:0] exp_high(input logic s, input logic l);
    int n;
    n = s ? PHYS_ADDR_WIDTH - SMALL_PAGE_SHIFT : PHYS_ADDR_WIDTH - LARGE_PAGE_SHIFT;
    if (!l) begin
      return 32'h0;
    end
    return 32'((64'h1 << (n - FRAME_LOW_BITS)) - 64'h1);
  endfunction : exp_high

  // Move to a register; an idle edge before each strobe avoids double drives
  task automatic wr(input logic [4:0] idx, input logic hi, input logic [31:0] d);
    @(posedge clk);
    #1 {cop_index, cop_high, cop_wdata, cop_wr} = {idx, hi, d, 1'b1};
    @(posedge clk);
    #1 cop_wr = 0;
  endtask : wr

  // Move from a register and compare in the answer cycle
  task automatic rd_chk(input logic [4:0] idx, input logic hi, input logic [31:0] exp);
    @(posedge clk);
    #1 {cop_index, cop_high, cop_rd} = {idx, hi, 1'b1};
    @(posedge clk);
    #1 cop_rd = 0;
    `CHK(cop_rvalid, 1'b1)
    `CHK(cop_rdata, exp)
  endtask : rd_chk

  // Low-word move, then a read of the same register on the very next edge
  task automatic wr_rd_chk(input logic [4:0] idx, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk);
    #1 {cop_index, cop_high, cop_wdata, cop_wr} = {idx, 1'b0, d, 1'b1};
    @(posedge clk);
    #1 {cop_wr, cop_rd} = 2'b01;
    @(posedge clk);
    #1 cop_rd = 0;
    `CHK(cop_rvalid, 1'b1)
    `CHK(cop_rdata, exp)
  endtask : wr_rd_chk

  // One pulse on an array request line
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1;
    @(posedge clk);
    #1 s = 0;
  endtask : pulse

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // Watchdog, far beyond the roughly 350 cycles the tests need
  initial begin
    #50000;
    error_cnt++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(50));
    repeat (12) @(posedge clk);
    #1 rst = 0;
    rd_chk(EVEN_INDEX, 0, 32'h0);
    rd_chk(ODD_INDEX, 0, 32'h0);
    rd_chk(5'h05, 0, 32'h0);
    `CHK(small_page_capability, 1'b1)
    `CHK(large_addr_capability, 1'b1)
    // All-ones probe in every layout; pad reads zero
    for (int m = 0; m < 4; m++) begin
      {large_addr_enable, small_page_enable} = 2'(m);
      wr(EVEN_INDEX, 1, '1);
      wr_rd_chk(EVEN_INDEX, '1, 32'h3fffffff);
      rd_chk(EVEN_INDEX, 1, exp_high(m[0], m[1]));
    end
    // A high-half move is dropped while the extended layout is off
    large_addr_enable = 0;
    wr(EVEN_INDEX, 1, 32'h0);
    large_addr_enable = 1;
    rd_chk(EVEN_INDEX, 1, exp_high(1'b1, 1'b1));
    // Random words, every pair of global bits, both page sizes
    for (int i = 0; i < 8; i++) begin
      sp = i[0];
      {large_addr_enable, small_page_enable} = {1'b0, sp};
      ev = $urandom();
      od = $urandom();
      {ev[0], od[0]} = {i[1], i[2]};
      wr(EVEN_INDEX, 0, ev);
      wr(ODD_INDEX, 0, od);
      rd_chk(EVEN_INDEX, 0, ev & 32'h3fffffff);
      rd_chk(ODD_INDEX, 0, od & 32'h3fffffff);
      pulse(write_translation);
      `CHK(tlb_wr_valid, 1'b1)
      `CHK(tlb_wr_entry.space_ignore, ev[0] & od[0])
      `CHK({tlb_wr_entry.pages[0].attr, tlb_wr_entry.pages[0].dirty, tlb_wr_entry.pages[0].valid}, ev[5:1])
      `CHK(tlb_wr_entry.pages[1].frame[23:0], od[29:6])
      if (sp) `CHK(tlb_wr_entry.pages[0].base[33:10], ev[29:6])
      else `CHK(tlb_wr_entry.pages[0].base[35:12], ev[29:6])
    end
    // Clear both, load back from the array: global lands in both bit 0s
    g = ev[0] & od[0];
    wr(EVEN_INDEX, 0, 32'h0);
    wr(ODD_INDEX, 0, 32'h0);
    pulse(read_translation);
    rd_chk(EVEN_INDEX, 0, (ev & 32'h3ffffffe) | {31'h0, g});
    rd_chk(ODD_INDEX, 0, (od & 32'h3ffffffe) | {31'h0, g});
    // Address error leaves contents alone in this design
    pulse(address_error);
    rd_chk(ODD_INDEX, 0, (od & 32'h3ffffffe) | {31'h0, g});
    // Random matching, permission and fault-capture traffic
    repeat (200) begin
      {probe_vpn_hit, probe_global, access_req, access_store} = 4'($urandom());
      {access_dirty, access_valid, virtual_side_write, fault_capture} = 4'($urandom());
      probe_tag = TAG_WIDTH'($urandom());
      address_space_tag = $urandom_range(1) ? probe_tag : TAG_WIDTH'($urandom());
      fc = fault_capture;
      #1;
      `CHK(tag_hit, probe_vpn_hit & (probe_global | (probe_tag == address_space_tag)))
      `CHK(invalid_exc, access_req & ~access_valid)
      `CHK(modified_exc, access_req & access_valid & access_store & ~access_dirty)
      @(posedge clk);
      #1;
      `CHK(fault_addr_update, fc)
    end
    give_verdict();
  end
endmodule : tlb_entry_low_regs_bench
`default_nettype wire
